// File: nibble_alu_pkg.sv
// Constants, opcodes and register map shared by the nibble arithmetic unit files
package nibble_alu_pkg;

  localparam int DATA_W = 4;
  localparam int ADDR_W = 8;
  localparam int BUS_W = 32;

  // Register byte offsets on the bus
  localparam logic [ADDR_W-1:0] OFF_OP = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ACC = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

  // Field positions in the operation register
  localparam int OP_LSB = 0;
  localparam int OP_W = 5;
  localparam int OPND_LSB = 8;

  // Flag byte layout {general, branch, zero, carry}
  localparam int FLAG_CF = 0;
  localparam int FLAG_ZF = 1;
  localparam int FLAG_SF = 2;
  localparam int FLAG_GF = 3;

  // Status register layout
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;
  localparam int ST_TAKEN = 2;
  localparam int ST_SP_LSB = 4;

  localparam logic RST_SF = 1'b1;
  localparam int STACK_DEPTH = 15;

  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_LOAD       = 5'h01,
    OP_ADD        = 5'h02,
    OP_ADD_WITH_CARRY_OP       = 5'h03,
    OP_REVERSE_SUBTRACT_BORROW_OP      = 5'h04,
    OP_COMPARE_OP       = 5'h05,
    OP_AND        = 5'h06,
    OP_OR         = 5'h07,
    OP_XOR        = 5'h08,
    OP_ROTATE_LEFT_THROUGH_CARRY       = 5'h09,
    OP_ROTATE_RIGHT_THROUGH_CARRY       = 5'h0a,
    OP_COPY_CARRY_THEN_SET   = 5'h0b,
    OP_INVERT_CARRY_THEN_CLEAR    = 5'h0c,
    OP_SET_GF     = 5'h0d,
    OP_CLR_GF     = 5'h0e,
    OP_TEST_GF    = 5'h0f,
    OP_BRANCH     = 5'h10,
    OP_INT_ENTER  = 5'h11,
    OP_INT_RETURN = 5'h12
  } op_t;

  typedef enum logic [2:0] {
    ALU_PASS = 3'b000,
    ALU_ADD  = 3'b001,
    ALU_AND  = 3'b010,
    ALU_OR   = 3'b011,
    ALU_XOR  = 3'b100,
    ALU_ROL  = 3'b101,
    ALU_ROR  = 3'b110
  } alu_mode_t;

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

endpackage

// File: alu_if.sv
// Operand and result wires between the flag core and the arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
  import nibble_alu_pkg::*;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic alu_carry_input;
  alu_mode_t mode;
  logic [DATA_W-1:0] result;
  logic carry;
  logic zero;
  modport user (output a, output b, output alu_carry_input, output mode, input result, input carry, input zero);
  modport unit (input a, input b, input alu_carry_input, input mode, output result, output carry, output zero);
endinterface
`default_nettype wire

// File: nibble_alu.sv
// Combinational 4-bit arithmetic and logic unit
`timescale 1ns/1ps
`default_nettype none
module nibble_alu
  import nibble_alu_pkg::*;
(
  alu_if.unit alu
);
  logic [DATA_W:0] sum;

  always_comb begin
    sum = {1'b0, alu.a} + {1'b0, alu.b} + {{DATA_W{1'b0}}, alu.alu_carry_input};
    alu.carry = 1'b0;
    alu.result = alu.b;
    case (alu.mode)
      ALU_ADD: begin
        // Subtraction arrives here as a plus inverted b plus the carry input (one for compare); carry then means no borrow
        alu.result = sum[DATA_W-1:0];
        alu.carry = sum[DATA_W];
      end
      ALU_AND: alu.result = alu.a & alu.b;
      ALU_OR: alu.result = alu.a | alu.b;
      ALU_XOR: alu.result = alu.a ^ alu.b;
      ALU_ROL: begin
        alu.result = {alu.a[DATA_W-2:0], alu.alu_carry_input};
        alu.carry = alu.a[DATA_W-1];
      end
      ALU_ROR: begin
        alu.result = {alu.alu_carry_input, alu.a[DATA_W-1:1]};
        alu.carry = alu.a[0];
      end
      default: alu.result = alu.b;
    endcase
    alu.zero = is_zero(alu.result);
  end
endmodule
`default_nettype wire

// File: nibble_alu_core.sv
// Working register, four flags and flag stack behind an AHB-Lite slave
//
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module nibble_alu_core
  import nibble_alu_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [BUS_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [BUS_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [BUS_W-1:0] hrdata
);
  localparam int SP_W = $clog2(DEPTH + 1);
  localparam logic [SP_W-1:0] SP_ONE = SP_W'(1);
  localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);

  alu_if alu();

  logic dp_valid_q;
  logic dp_write_q;
  logic [ADDR_W-1:0] dp_addr_q;
  logic rd_done_q;
  logic [BUS_W-1:0] hrdata_q;
  logic [DATA_W-1:0] acc_q;
  logic cf_q;
  logic zf_q;
  logic sf_q;
  logic gf_q;
  logic [DATA_W-1:0] stk_q [DEPTH];
  logic [SP_W-1:0] sp_q;
  logic taken_q;
  logic last_c_q;
  logic last_z_q;
  logic [OP_W-1:0] op_q;
  logic [DATA_W-1:0] opnd_q;

  logic wr_en;
  logic exec;
  logic acc_wr;
  logic flags_wr;
  op_t op;
  logic [DATA_W-1:0] opnd;
  logic acc_we;
  logic cf_we;
  logic zf_we;
  logic sf_d;
  logic cf_d;
  logic push;
  logic pop;
  logic [DATA_W-1:0] top;

  // Address phase is taken only when the bus is ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= '0;
    end else if (hready) begin
      dp_valid_q <= hsel && htrans[1];
      dp_write_q <= hwrite;
      dp_addr_q <= haddr[ADDR_W-1:0];
    end
  end

  // One wait state on reads while the registered read data is loaded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= dp_valid_q && !dp_write_q && !rd_done_q;
    end
  end

  assign hreadyout = !(dp_valid_q && !dp_write_q && !rd_done_q);
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else if (dp_valid_q && !dp_write_q && !rd_done_q) begin
      hrdata_q <= '0;
      if (dp_addr_q == OFF_OP) begin
        hrdata_q[OPND_LSB +: DATA_W] <= opnd_q;
        hrdata_q[OP_LSB +: OP_W] <= op_q;
      end else if (dp_addr_q == OFF_ACC) begin
        hrdata_q[DATA_W-1:0] <= acc_q;
      end else if (dp_addr_q == OFF_FLAGS) begin
        hrdata_q[DATA_W-1:0] <= {gf_q, sf_q, zf_q, cf_q};
      end else if (dp_addr_q == OFF_STATUS) begin
        hrdata_q[ST_SP_LSB +: SP_W] <= sp_q;
        hrdata_q[ST_TAKEN] <= taken_q;
        hrdata_q[ST_ZERO] <= last_z_q;
        hrdata_q[ST_CARRY] <= last_c_q;
      end
    end
  end

  // Writes land in the data phase; unmapped offsets are ignored
  assign wr_en = dp_valid_q && dp_write_q;
  assign exec = wr_en && (dp_addr_q == OFF_OP);
  assign acc_wr = wr_en && (dp_addr_q == OFF_ACC);
  assign flags_wr = wr_en && (dp_addr_q == OFF_FLAGS);
  assign op = op_t'(hwdata[OP_LSB +: OP_W]);
  assign opnd = hwdata[OPND_LSB +: DATA_W];
  assign top = stk_q[sp_q - SP_ONE];

  nibble_alu u_alu (
    .alu(alu.unit)
  );

  // Instruction decode
  always_comb begin
    alu.a = acc_q;
    alu.b = opnd;
    alu.alu_carry_input = 1'b0;
    alu.mode = ALU_PASS;
    acc_we = 1'b0;
    cf_we = 1'b0;
    zf_we = 1'b0;
    cf_d = alu.carry;
    sf_d = 1'b1;
    push = 1'b0;
    pop = 1'b0;
    case (op)
      OP_LOAD: begin
        acc_we = 1'b1;
        zf_we = 1'b1;
      end
      OP_ADD: begin
        alu.mode = ALU_ADD;
        acc_we = 1'b1;
        zf_we = 1'b1;
        sf_d = !alu.carry;
      end
      OP_ADD_WITH_CARRY_OP: begin
        alu.mode = ALU_ADD;
        alu.alu_carry_input = cf_q;
        acc_we = 1'b1;
        cf_we = 1'b1;
        zf_we = 1'b1;
        sf_d = !alu.carry;
      end
      OP_REVERSE_SUBTRACT_BORROW_OP: begin
        // Reverse subtract: operand minus working register
        alu.mode = ALU_ADD;
        alu.a = opnd;
        alu.b = ~acc_q;
        alu.alu_carry_input = cf_q;
        acc_we = 1'b1;
        cf_we = 1'b1;
        zf_we = 1'b1;
        sf_d = alu.carry;
      end
      OP_COMPARE_OP: begin
        alu.mode = ALU_ADD;
        alu.a = opnd;
        alu.b = ~acc_q;
        alu.alu_carry_input = 1'b1;
        cf_we = 1'b1;
        zf_we = 1'b1;
        sf_d = !alu.zero;
      end
      OP_AND: begin
        alu.mode = ALU_AND;
        acc_we = 1'b1;
        zf_we = 1'b1;
      end
      OP_OR: begin
        alu.mode = ALU_OR;
        acc_we = 1'b1;
        zf_we = 1'b1;
      end
      OP_XOR: begin
        alu.mode = ALU_XOR;
        acc_we = 1'b1;
        zf_we = 1'b1;
      end
      OP_ROTATE_LEFT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        alu.mode = (op == OP_ROTATE_LEFT_THROUGH_CARRY) ? ALU_ROL : ALU_ROR;
        alu.alu_carry_input = cf_q;
        acc_we = 1'b1;
        cf_we = 1'b1;
        zf_we = 1'b1;
        sf_d = !alu.carry;
      end
      OP_COPY_CARRY_THEN_SET: begin
        sf_d = cf_q;
        cf_we = 1'b1;
        cf_d = 1'b1;
      end
      OP_INVERT_CARRY_THEN_CLEAR: begin
        sf_d = !cf_q;
        cf_we = 1'b1;
        cf_d = 1'b0;
      end
      OP_TEST_GF: sf_d = gf_q;
      OP_INT_ENTER: push = sp_q != SP_FULL;
      OP_INT_RETURN: begin
        pop = sp_q != '0;
        sf_d = pop ? top[FLAG_SF] : sf_q;
      end
      default: sf_d = 1'b1;
    endcase
  end

  // Working register and carry, zero and general flags are not reset
  always_ff @(posedge hclk) begin
    if (exec && acc_we) begin
      acc_q <= alu.result;
    end else if (acc_wr) begin
      acc_q <= hwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge hclk) begin
    if (exec && pop) begin
      cf_q <= top[FLAG_CF];
      zf_q <= top[FLAG_ZF];
      gf_q <= top[FLAG_GF];
    end else if (exec) begin
      if (cf_we) begin
        cf_q <= cf_d;
      end
      if (zf_we) begin
        zf_q <= alu.zero;
      end
      if (op == OP_SET_GF) begin
        gf_q <= 1'b1;
      end else if (op == OP_CLR_GF) begin
        gf_q <= 1'b0;
      end
    end else if (acc_wr) begin
      zf_q <= is_zero(hwdata[DATA_W-1:0]);
    end else if (flags_wr) begin
      cf_q <= hwdata[FLAG_CF];
      zf_q <= hwdata[FLAG_ZF];
      gf_q <= hwdata[FLAG_GF];
    end
  end

  // Only the branch flag has a reset value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sf_q <= RST_SF;
    end else if (exec) begin
      sf_q <= sf_d;
    end else if (flags_wr) begin
      sf_q <= hwdata[FLAG_SF];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      taken_q <= 1'b0;
      last_c_q <= 1'b0;
      last_z_q <= 1'b0;
      op_q <= '0;
      opnd_q <= '0;
    end else if (exec) begin
      taken_q <= (op == OP_BRANCH) && sf_q;
      last_c_q <= alu.carry;
      last_z_q <= alu.zero;
      op_q <= op;
      opnd_q <= opnd;
    end
  end

  // Flag stack; a push when full or a pop when empty is dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= '0;
    end else if (exec && push) begin
      sp_q <= sp_q + SP_ONE;
    end else if (exec && pop) begin
      sp_q <= sp_q - SP_ONE;
    end
  end

  always_ff @(posedge hclk) begin
    if (exec && push) begin
      stk_q[sp_q] <= {gf_q, sf_q, zf_q, cf_q};
    end
  end

  logic first_q;
  logic [1:0] primed_q;
  logic [DATA_W-1:0] outer_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_q <= 1'b1;
      primed_q <= '0;
      outer_q <= '0;
    end else begin
      first_q <= 1'b0;
      primed_q <= primed_q | {flags_wr, acc_wr};
      if (exec && push && sp_q == '0) begin
        outer_q <= {gf_q, sf_q, zf_q, cf_q};
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_reset_branch_flag: assert property (first_q |-> sf_q)
    else $error("branch flag not one after reset");
  chk_add_with_carry_op_carry: assert property (exec && op == OP_ADD_WITH_CARRY_OP |=>
    {cf_q, acc_q} == $past({1'b0, acc_q} + {1'b0, opnd} + {4'h0, cf_q}))
    else $error("add with carry result or carry wrong");
  chk_reverse_subtract_borrow_op_borrow: assert property (exec && op == OP_REVERSE_SUBTRACT_BORROW_OP |=>
    cf_q == ($past({1'b0, opnd}) >= $past({1'b0, acc_q}) + $past({4'h0, !cf_q})))
    else $error("reverse subtract carry wrong");
  chk_compare_op_no_borrow: assert property (exec && op == OP_COMPARE_OP |=>
    cf_q == ($past(opnd) >= $past(acc_q)) && $stable(acc_q))
    else $error("compare carry wrong or register changed");
  chk_rotate_left_through_carry_shift: assert property (exec && op == OP_ROTATE_LEFT_THROUGH_CARRY |=>
    acc_q == {$past(acc_q[2:0]), $past(cf_q)} && cf_q == $past(acc_q[3]))
    else $error("rotate left through carry wrong");
  chk_rotate_right_through_carry_shift: assert property (exec && op == OP_ROTATE_RIGHT_THROUGH_CARRY |=>
    acc_q == {$past(cf_q), $past(acc_q[3:1])} && cf_q == $past(acc_q[0]))
    else $error("rotate right through carry wrong");
  chk_copy_carry: assert property (exec && op == OP_COPY_CARRY_THEN_SET |=> sf_q == $past(cf_q) && cf_q)
    else $error("copy carry test wrong");
  chk_invert_carry: assert property (exec && op == OP_INVERT_CARRY_THEN_CLEAR |=> sf_q == !$past(cf_q) && !cf_q)
    else $error("inverting carry test wrong");
  chk_zero_capture: assert property (exec && acc_we |=> zf_q == (acc_q == 4'h0))
    else $error("zero flag does not match result");
  chk_branch_taken: assert property (exec && op == OP_BRANCH |=> taken_q == $past(sf_q) && sf_q)
    else $error("branch decision wrong");
  chk_flag_restore: assert property (exec && pop && sp_q == SP_ONE |=>
    {gf_q, sf_q, zf_q, cf_q} == outer_q)
    else $error("flags not restored on interrupt return");
  chk_hold_state: assert property (primed_q == 2'b11 && !exec && !acc_wr && !flags_wr |=>
    $stable(acc_q) && $stable(cf_q) && $stable(sf_q) && $stable(gf_q))
    else $error("register or flag changed without an operation");

endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the nibble flag core over AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nibble_alu_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  wire logic hready;
  int err_total, total_checks, cycles;

  // Single slave, so its own ready is the bus ready
  assign hready = hreadyout;

  nibble_alu_core u_nibble_alu_core (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata)
  );

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic stop_test();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hung handshake short
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready and read data are sampled at the rising edge; a hang is left to the cycle limit
  task automatic bus_wait(output logic [31:0] d);
    @(posedge hclk);
    while (hready !== 1'b1) begin
      @(posedge hclk);
    end
    d = hrdata;
  endtask

  task automatic ahb_addr(input logic [7:0] a, input logic w);
    logic [31:0] x;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    bus_wait(x);
  endtask

  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb_addr(a, 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    bus_wait(x);
  endtask

  task automatic ahb_rd(input logic [7:0] a, output logic [31:0] d);
    ahb_addr(a, 1'b0);
    htrans <= 2'b00;
    hsel <= 1'b0;
    bus_wait(d);
  endtask

  task automatic do_op(input op_t op, input logic [3:0] opnd);
    ahb_wr(OFF_OP, {20'h0, opnd, 3'h0, op});
  endtask

  task automatic chk_flags(input logic [3:0] exp);
    ahb_rd(OFF_FLAGS, rd);
    chk(rd, {28'h0, exp});
  endtask

  // Flags are written after the register, since a register write also sets zero
  task automatic run_case(input logic [3:0] a0, input logic [3:0] f0, input op_t op,
                          input logic [3:0] opnd, input logic [3:0] a1, input logic [3:0] f1);
    ahb_wr(OFF_ACC, {28'h0, a0});
    ahb_wr(OFF_FLAGS, {28'h0, f0});
    do_op(op, opnd);
    ahb_rd(OFF_ACC, rd);
    chk(rd, {28'h0, a1});
    chk_flags(f1);
  endtask

  task automatic test_reset();
    ahb_rd(OFF_FLAGS, rd);
    chk(rd & 32'h4, 32'h4);
    ahb_rd(OFF_STATUS, rd);
    chk(rd, 32'h0);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic test_arith();
    run_case(4'hc, 4'h5, OP_ADD_WITH_CARRY_OP, 4'h5, 4'h2, 4'h1);
    run_case(4'h7, 4'h4, OP_ADD, 4'h9, 4'h0, 4'h2);
    ahb_rd(OFF_STATUS, rd);
    chk(rd & 32'h3, 32'h3);
    run_case(4'hc, 4'h1, OP_REVERSE_SUBTRACT_BORROW_OP, 4'h5, 4'h9, 4'h0);
    run_case(4'h2, 4'h1, OP_REVERSE_SUBTRACT_BORROW_OP, 4'h2, 4'h0, 4'h7);
    run_case(4'h2, 4'h0, OP_REVERSE_SUBTRACT_BORROW_OP, 4'h2, 4'hf, 4'h0);
    run_case(4'hc, 4'h1, OP_COMPARE_OP, 4'h5, 4'hc, 4'h4);
    run_case(4'h2, 4'h0, OP_COMPARE_OP, 4'h2, 4'h2, 4'h3);
  endtask

  task automatic test_rotate();
    run_case(4'hb, 4'h1, OP_ROTATE_LEFT_THROUGH_CARRY, 4'h0, 4'h7, 4'h1);
    run_case(4'h8, 4'h0, OP_ROTATE_LEFT_THROUGH_CARRY, 4'h0, 4'h0, 4'h3);
    run_case(4'h8, 4'h1, OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h0, 4'hc, 4'h4);
    run_case(4'h1, 4'h0, OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h0, 4'h0, 4'h3);
  endtask

  task automatic test_carry_tests();
    run_case(4'h5, 4'h1, OP_COPY_CARRY_THEN_SET, 4'h0, 4'h5, 4'h5);
    run_case(4'h5, 4'h0, OP_COPY_CARRY_THEN_SET, 4'h0, 4'h5, 4'h1);
    run_case(4'h5, 4'h1, OP_INVERT_CARRY_THEN_CLEAR, 4'h0, 4'h5, 4'h0);
    run_case(4'h5, 4'h0, OP_INVERT_CARRY_THEN_CLEAR, 4'h0, 4'h5, 4'h4);
  endtask

  task automatic test_general();
    run_case(4'h3, 4'h0, OP_SET_GF, 4'h0, 4'h3, 4'hc);
    run_case(4'h3, 4'hf, OP_CLR_GF, 4'h0, 4'h3, 4'h7);
    run_case(4'h3, 4'h8, OP_TEST_GF, 4'h0, 4'h3, 4'hc);
    run_case(4'h3, 4'h4, OP_TEST_GF, 4'h0, 4'h3, 4'h0);
    run_case(4'h3, 4'h0, OP_NOP, 4'h9, 4'h3, 4'h4);
    run_case(4'h3, 4'h1, OP_LOAD, 4'h0, 4'h0, 4'h7);
    run_case(4'h0, 4'h0, OP_LOAD, 4'h6, 4'h6, 4'h4);
  endtask

  task automatic test_branch();
    run_case(4'h1, 4'h4, OP_BRANCH, 4'h0, 4'h1, 4'h4);
    ahb_rd(OFF_STATUS, rd);
    chk(rd & 32'h4, 32'h4);
    run_case(4'h1, 4'h0, OP_BRANCH, 4'h0, 4'h1, 4'h4);
    ahb_rd(OFF_STATUS, rd);
    chk(rd & 32'h4, 32'h0);
  endtask

  // Two nested entries check that the flags come back last in, first out
  task automatic test_interrupt();
    run_case(4'h3, 4'ha, OP_INT_ENTER, 4'h0, 4'h3, 4'he);
    ahb_wr(OFF_FLAGS, 32'h1);
    do_op(OP_INT_ENTER, 4'h0);
    ahb_wr(OFF_FLAGS, 32'h4);
    do_op(OP_INT_RETURN, 4'h0);
    chk_flags(4'h1);
    do_op(OP_INT_RETURN, 4'h0);
    chk_flags(4'ha);
  endtask

  task automatic test_unmapped();
    ahb_wr(8'h14, 32'hf);
    ahb_rd(8'h10, rd);
    chk(rd, 32'h0);
    ahb_rd(OFF_ACC, rd);
    chk(rd, 32'h3);
    ahb_rd(OFF_OP, rd);
    chk(rd, 32'h12);
  endtask

  // Reset in mid-run must set only the branch flag
  task automatic test_midreset();
    ahb_wr(OFF_ACC, 32'h9);
    ahb_wr(OFF_FLAGS, 32'hb);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_flags(4'hf);
    ahb_rd(OFF_ACC, rd);
    chk(rd, 32'h9);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_total = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    test_reset();
    test_arith();
    test_rotate();
    test_carry_tests();
    test_general();
    test_branch();
    test_interrupt();
    test_unmapped();
    test_midreset();
    stop_test();
  end
endmodule
`default_nettype wire
